// ---- rtl/tsw_consts.vh ----
// constants for the connection word decoder
`ifndef TSW_CONSTS_VH
`define TSW_CONSTS_VH

// connection word field positions
`define TSW_CW_LOOPBACK 15
`define TSW_CW_CONST_DELAY 14
`define TSW_CW_PROC_CHAN 13
`define TSW_CW_CTRL_OUT 12
`define TSW_CW_OUT_EN 11
`define TSW_CW_SRC_STREAM_HI 8
`define TSW_CW_SRC_STREAM_LO 7
`define TSW_CW_SRC_CHAN_HI 4
`define TSW_CW_SRC_CHAN_LO 0
`define TSW_CW_PROC_BYTE_HI 7

// stream and frame geometry
`define TSW_NUM_STREAMS 4
`define TSW_LAST_STREAM 2'h3
`define TSW_LAST_CHAN 5'h1f
`define TSW_LAST_BIT 3'h7

// register map (byte addresses)
`define TSW_CM_BASE 12'h000
`define TSW_CM_LAST 12'h1fc
`define TSW_CTRL_ADDR 12'h200
`define TSW_STAT_ADDR 12'h204
`define TSW_CTRL_RUN 0
`define TSW_CTRL_RESET 1'h0
`define TSW_CW_RESET 16'h0000
`define TSW_RESP_OKAY 2'h0
`define TSW_RESP_SLVERR 2'h2

// serial timing
`define TSW_CLK_PERIOD_NS 8
`define TSW_BIT_TIME_NS 488
`define TSW_BIT_CYC (`TSW_BIT_TIME_NS / `TSW_CLK_PERIOD_NS)
`define TSW_SAMPLE_DIV (`TSW_BIT_CYC / 2)
`define TSW_STORE_FIRST 6'h1f

`endif

// ---- rtl/tsw_conn_mem.v ----
// connection memory, 128 words of 16 bits, one write and two read ports
`timescale 1ns/1ps
`default_nettype none
`include "tsw_consts.vh"
module tsw_conn_mem (
    // clock and write port
    input wire clk,
    input wire we,
    input wire [1:0] wbe,
    input wire [6:0] waddr,
    input wire [15:0] wdata,
    // frame side read port
    input wire [6:0] raddr_a,
    output wire [15:0] rdata_a,
    // software side read port
    input wire [6:0] raddr_b,
    output wire [15:0] rdata_b
);
    reg [15:0] mem [0:127];
    integer i;

    // contents are defined so no stray channel drives after start
    initial begin
        for (i = 0; i < 128; i = i + 1) begin
            mem[i] = `TSW_CW_RESET;
        end
    end

    always @(posedge clk) begin
        if (we && wbe[0]) begin
            mem[waddr][7:0] <= wdata[7:0];
        end
        if (we && wbe[1]) begin
            mem[waddr][15:8] <= wdata[15:8];
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule // tsw_conn_mem
`default_nettype wire

// ---- rtl/tsw_data_mem.v ----
// received data memory, two frame banks of 128 bytes
`timescale 1ns/1ps
`default_nettype none
module tsw_data_mem (
    // clock and write port
    input wire clk,
    input wire we,
    input wire [7:0] waddr,
    input wire [7:0] wdata,
    // read port
    input wire [7:0] raddr,
    output wire [7:0] rdata
);
    reg [7:0] mem [0:255];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule // tsw_data_mem
`default_nettype wire

// ---- rtl/tsw_conn_word_decode.v ----
// connection word decoder and time slot switch with axi4-lite access
//
// Overview of operation
// RULE_01: loopback bit feeds own transmit into receive
// RULE_02: software zeroes input offset for loopback streams
// RULE_03: bit 14 picks variable or constant delay
// RULE_04: processor bit sends word itself, not switched data
// RULE_05: processor mode sends only the low byte
// RULE_06: otherwise source fields address the data memory
// RULE_07: bit 12 on control pin one channel early
// RULE_08: bit 11 enables output driver per slot
// RULE_09: software writes zero to unused word bits
// RULE_10: bits 8,7 give source stream number
// RULE_11: bits 4-0 give source channel number
// RULE_12: four streams, numbered zero through three
// RULE_13: thirty-two channels per frame, last is 31
// RULE_14: 128 words, each read once per channel; the code reads each word once per frame, four words per channel
`timescale 1ns/1ps
`default_nettype none
`include "tsw_consts.vh"
module tsw_conn_word_decode (
    // clock, reset and freeze
    input wire clk,
    input wire rst_n,
    input wire ce,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // serial streams
    input wire [3:0] rx_pin,
    output reg [3:0] tx_out,
    output reg [3:0] tx_oe,
    // frame timing and external control
    output reg control_channel_out,
    output reg frame_pulse
);
    // software state
    reg ctrl_run;
    reg aw_hold;
    reg w_hold;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // frame timing
    reg [5:0] div;
    reg [2:0] bit_cnt;
    reg [4:0] chan;
    reg par;

    // per-stream state
    reg [3:0] rx_meta;
    reg [3:0] rx_sync;
    reg [15:0] cur_word [0:3];
    reg [15:0] nxt_word [0:3];
    reg [7:0] nxt_byte [0:3];
    reg [7:0] tx_shift [0:3];
    reg [7:0] rx_shift [0:3];

    wire tick;
    wire chan_start;
    wire sample;
    wire prefetch;
    wire [1:0] pf_stream;
    wire [15:0] pf_word;
    wire [15:0] cm_rdata_a;
    wire [15:0] cm_rdata_b;
    wire [7:0] dm_rdata;
    wire [4:0] src_chan;
    wire [1:0] src_stream;
    wire dm_bank;
    wire [5:0] wr_off;
    wire dm_we;
    wire do_write;
    wire cm_hit_w;
    wire cm_hit_r;
    wire [31:0] stat_word;

    assign tick = ctrl_run && (div == `TSW_BIT_CYC - 1);
    assign chan_start = tick && (bit_cnt == `TSW_LAST_BIT);
    assign sample = ctrl_run && (div == `TSW_SAMPLE_DIV);

    // next channel's words and bytes are fetched in bit 0, eight cycles:
    // four word reads, then four data reads, before the control pin needs them
    assign prefetch = ctrl_run && (bit_cnt == 3'h0) && (div < 6'h08);
    assign pf_stream = div[1:0];
    assign pf_word = nxt_word[pf_stream];
    assign src_stream = pf_word[`TSW_CW_SRC_STREAM_HI:`TSW_CW_SRC_STREAM_LO];
    assign src_chan = pf_word[`TSW_CW_SRC_CHAN_HI:`TSW_CW_SRC_CHAN_LO];

    // constant delay reads the last finished frame; variable delay reads
    // whichever bank got the source channel most recently
    assign dm_bank = pf_word[`TSW_CW_CONST_DELAY] ? ~par :
                     ((src_chan < chan) ? par : ~par); // [RULE_03]

    // received bytes are stored one stream per cycle after the last bit
    assign wr_off = div - `TSW_STORE_FIRST;
    assign dm_we = ce && ctrl_run && (bit_cnt == `TSW_LAST_BIT) &&
                   (div > `TSW_SAMPLE_DIV) &&
                   (div <= `TSW_SAMPLE_DIV + 4);

    assign do_write = aw_hold && w_hold && !s_axi_bvalid;
    assign cm_hit_w = (aw_addr <= `TSW_CM_LAST);
    assign cm_hit_r = (s_axi_araddr <= `TSW_CM_LAST);
    assign stat_word = {15'h0000, ctrl_run, 7'h00, par, 3'h0, chan};

    tsw_conn_mem u_conn_mem (
        .clk(clk),
        .we(ce && do_write && cm_hit_w),
        .wbe(w_strb[1:0]),
        .waddr(aw_addr[8:2]),
        .wdata(w_data[15:0]),
        .raddr_a({pf_stream, chan + 5'h01}), // [RULE_14]
        .rdata_a(cm_rdata_a),
        .raddr_b(s_axi_araddr[8:2]),
        .rdata_b(cm_rdata_b)
    );

    tsw_data_mem u_data_mem (
        .clk(clk),
        .we(dm_we),
        .waddr({par, wr_off[1:0], chan}),
        .wdata(rx_shift[wr_off[1:0]]),
        .raddr({dm_bank, src_stream, src_chan}), // [RULE_06] [RULE_10] [RULE_11]
        .rdata(dm_rdata)
    );

    // frame counters; they rest at frame start while stopped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 6'h00;
            bit_cnt <= 3'h0;
            chan <= 5'h00;
            par <= 1'b0;
            frame_pulse <= 1'b0;
        end else if (ce) begin
            if (!ctrl_run) begin
                div <= 6'h00;
                bit_cnt <= 3'h0;
                chan <= 5'h00;
                frame_pulse <= 1'b0;
            end else if (tick) begin
                div <= 6'h00;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == `TSW_LAST_BIT) begin
                    chan <= chan + 5'h01;
                    if (chan == `TSW_LAST_CHAN) begin // [RULE_13]
                        par <= ~par;
                    end
                end
                frame_pulse <= (chan == `TSW_LAST_CHAN) &&
                               (bit_cnt == `TSW_LAST_BIT);
            end else begin
                div <= div + 6'h01;
            end
        end
    end

    // prefetch of the next channel's words and outgoing bytes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nxt_word[0] <= `TSW_CW_RESET;
            nxt_word[1] <= `TSW_CW_RESET;
            nxt_word[2] <= `TSW_CW_RESET;
            nxt_word[3] <= `TSW_CW_RESET;
            nxt_byte[0] <= 8'h00;
            nxt_byte[1] <= 8'h00;
            nxt_byte[2] <= 8'h00;
            nxt_byte[3] <= 8'h00;
        end else if (ce && prefetch) begin
            if (!div[2]) begin
                nxt_word[pf_stream] <= cm_rdata_a; // [RULE_14]
            end else if (pf_word[`TSW_CW_PROC_CHAN]) begin
                nxt_byte[pf_stream] <=
                    pf_word[`TSW_CW_PROC_BYTE_HI:0]; // [RULE_04] [RULE_05]
            end else begin
                nxt_byte[pf_stream] <= dm_rdata; // [RULE_06]
            end
        end
    end

    // control pin carries bit 12 of the next channel, two bit times
    // per stream, stream 0 first
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_channel_out <= 1'b0;
        end else if (ce) begin
            if (!ctrl_run) begin
                control_channel_out <= 1'b0;
            end else if (sample) begin
                control_channel_out <=
                    nxt_word[bit_cnt[2:1]][`TSW_CW_CTRL_OUT]; // [RULE_07]
            end
        end
    end

    // pin synchroniser; only the second stage is read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 4'h0;
            rx_sync <= 4'h0;
        end else if (ce) begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    genvar s;
    generate
        for (s = 0; s < `TSW_NUM_STREAMS; s = s + 1) begin : g_stream // [RULE_12]
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cur_word[s] <= `TSW_CW_RESET;
                    tx_shift[s] <= 8'h00;
                    rx_shift[s] <= 8'h00;
                    tx_out[s] <= 1'b0;
                    tx_oe[s] <= 1'b0;
                end else if (ce) begin
                    if (!ctrl_run) begin
                        tx_oe[s] <= 1'b0;
                    end else if (chan_start) begin
                        cur_word[s] <= nxt_word[s];
                        tx_shift[s] <= {nxt_byte[s][6:0], 1'b0};
                        tx_out[s] <= nxt_byte[s][7];
                        tx_oe[s] <= nxt_word[s][`TSW_CW_OUT_EN]; // [RULE_08]
                    end else if (tick) begin
                        tx_shift[s] <= {tx_shift[s][6:0], 1'b0};
                        tx_out[s] <= tx_shift[s][7];
                    end
                    // loopback takes the bit this stream is sending now,
                    // which a nonzero input offset would misalign
                    if (sample) begin
                        rx_shift[s] <= {rx_shift[s][6:0],
                            cur_word[s][`TSW_CW_LOOPBACK] ? tx_out[s] :
                            rx_sync[s]}; // [RULE_01] [RULE_02]
                    end
                end
            end
        end
    endgenerate

    // axi4-lite write path; address and data taken in either order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TSW_RESP_OKAY;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            ctrl_run <= `TSW_CTRL_RESET;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_hold && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_hold && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `TSW_RESP_OKAY;
                if (aw_addr == `TSW_CTRL_ADDR) begin
                    if (w_strb[0]) begin
                        ctrl_run <= w_data[`TSW_CTRL_RUN];
                    end
                end else if (!cm_hit_w && aw_addr != `TSW_STAT_ADDR) begin
                    s_axi_bresp <= `TSW_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read path
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TSW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `TSW_RESP_OKAY;
                if (cm_hit_r) begin
                    s_axi_rdata <= {16'h0000, cm_rdata_b};
                end else if (s_axi_araddr == `TSW_CTRL_ADDR) begin
                    s_axi_rdata <= {31'h0000_0000, ctrl_run};
                end else if (s_axi_araddr == `TSW_STAT_ADDR) begin
                    s_axi_rdata <= stat_word;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `TSW_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // tsw_conn_word_decode
`default_nettype wire

// ---- dv/tsw_conn_word_decode_monitor.sv ----
// bus and serial timing checker for the connection word decoder
`timescale 1ns/1ps
`default_nettype none
module tsw_conn_word_decode_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // serial side
    input wire logic [3:0] tx_out,
    input wire logic [3:0] tx_oe,
    input wire logic control_channel_out,
    input wire logic frame_pulse
);
    logic fp_d;
    logic synced;
    logic [13:0] pos;
    wire [5:0] pos_bit = 6'(pos % 61);
    wire [8:0] pos_ch = 9'(pos % 488);
    // place in frame, restarted by the pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fp_d <= 1'b0;
            synced <= 1'b0;
            pos <= 14'h0000;
        end else begin
            fp_d <= frame_pulse;
            if (frame_pulse && !fp_d)
                synced <= 1'b1;
            pos <= (frame_pulse && !fp_d) ? 14'h0000 : pos + 14'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER:
        assert property (wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_RD_ANSWER:
        assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_HOLD:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_UNMAPPED:
        assert property (rd_taken ##0 s_axi_araddr > 12'h204
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    AST_PULSE:
        assert property ($rose(frame_pulse)
            |-> ##60 frame_pulse ##1 !frame_pulse)
        else $error("frame pulse width wrong");
    AST_FRAME_LEN:
        assert property ($rose(frame_pulse) && synced |-> pos == 14'h3cff)
        else $error("frame length wrong");
    AST_OE_SLOT:
        assert property (synced && $changed(tx_oe)
            |-> $rose(frame_pulse) || pos_ch == 9'h1e7)
        else $error("driver enable moved inside a slot");
    AST_TX_BIT:
        assert property (synced && $changed(tx_out)
            |-> $rose(frame_pulse) || pos_bit == 6'h3c)
        else $error("transmit bit moved inside a bit");
    AST_CTRL_TIME:
        assert property (synced && $changed(control_channel_out)
            |-> pos_bit inside {[6'h19:6'h23]})
        else $error("control pin moved off mid bit");
endmodule // tsw_conn_word_decode_monitor
bind tsw_conn_word_decode tsw_conn_word_decode_monitor tsw_mon_inst (
    .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .tx_out, .tx_oe, .control_channel_out, .frame_pulse);
`default_nettype wire

// ---- dv/tsw_stream_peer.sv ----
// far-side stream source, a known byte in every slot
`timescale 1ns/1ps
`default_nettype none
module tsw_stream_peer (
    // clock and frame timing
    input wire logic clk,
    input wire logic frame_pulse,
    // receive lines of the device
    output logic [3:0] rx_pin
);
    logic fp_d = 1'b0;
    logic synced = 1'b0;
    logic par = 1'b0;
    logic [13:0] pos = 14'h0000;
    wire [4:0] ch = 5'(pos / 488);
    wire [2:0] bi = 3'(7 - pos / 61 % 8);
    initial rx_pin = 4'h0;
    // byte is channel, frame parity, stream: delay modes then differ
    always @(posedge clk) begin
        fp_d <= frame_pulse;
        if (frame_pulse && !fp_d) begin
            synced <= 1'b1;
            par <= ~par;
        end
        pos <= (frame_pulse && !fp_d) ? 14'h0000 : pos + 14'h0001;
        // frame aligned, no input offset
        for (int s = 0; s < 4; s++)
            rx_pin[s] <= synced ? 1'({ch, par, 2'(s)} >> bi) : ~rx_pin[s];
    end
endmodule // tsw_stream_peer
`default_nettype wire

// ---- dv/tsw_conn_word_decode_bench.sv ----
// testbench for the connection word decoder
`timescale 1ns/1ps
`default_nettype none
module tsw_conn_word_decode_bench;
    logic clk, rst_n, ce, fp_d, control_channel_out, frame_pulse;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, rx_pin, tx_out, tx_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int num_errors = 0;
    int checks = 0;
    logic [13:0] pos;
    logic [7:0] cap [4][32], oecap [4][32], ccap [32];
    logic [11:0] wa [7] = '{12'h00c, 12'h090, 12'h094, 12'h118,
        12'h19c, 12'h0b0, 12'h1fc};
    logic [15:0] wv [7] = '{16'h38a5, 16'h0909, 16'h4982, 16'ha83c,
        16'h0906, 16'h1000, 16'h2881};
    tsw_conn_word_decode tsw_conn_word_decode_inst (.clk, .rst_n, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_pin, .tx_out, .tx_oe, .control_channel_out,
        .frame_pulse);
    tsw_stream_peer tsw_stream_peer_inst (.clk, .frame_pulse, .rx_pin);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // mid-bit sampling keeps clear of the launch edge
    always @(posedge clk) begin
        fp_d <= frame_pulse;
        pos <= (frame_pulse && !fp_d) ? 14'h0000 : pos + 14'h0001;
        if (pos % 61 == 30 && pos < 15616) for (int s = 0; s < 4; s++) begin
            cap[s][pos / 488][7 - pos / 61 % 8] <= tx_out[s];
            oecap[s][pos / 488][7 - pos / 61 % 8] <= tx_oe[s];
        end
        if (pos % 61 == 45 && pos < 15616)
            ccap[pos / 488][pos / 61 % 8] <= control_channel_out;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // a lost response is a failure, not a silent default
        if (s_axi_bvalid !== 1'b1) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic chk_word(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, exp);
        chk_word(32'(got), 32'(exp));
    endtask
    task automatic chk_slot(input int s, c, input logic [7:0] b, oe);
        chk_word(32'(oecap[s][c]), 32'(oe));
        if (oe != 8'h00)
            chk_word(32'(cap[s][c]), 32'(b));
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(8 * 90000);
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        rst_n = 1'b0;
        ce = 1'b1;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h200, d, r);
        chk_word(d, 32'h0000_0000);
        rd(12'h300, d, r);
        chk_resp(r, 2'h2);
        wr(12'h300, 32'h0000_0001, r);
        chk_resp(r, 2'h2);
        // unused word bits left zero
        for (int i = 0; i < 7; i++) begin
            wr(wa[i], 32'(wv[i]), r);
            rd(wa[i], d, r);
            chk_word(d, 32'(wv[i]));
        end
        $display("test registers done");
        wr(12'h200, 32'h0000_0001, r);
        // fourth full frame: constant delay reads the frame before
        repeat (4) @(posedge frame_pulse);
        chk_slot(0, 3, 8'ha5, 8'hff);
        chk_slot(1, 4, 8'h4a, 8'hff);
        chk_slot(1, 5, 8'h13, 8'hff);
        chk_slot(3, 7, 8'h3c, 8'hff);
        chk_slot(3, 31, 8'h81, 8'hff);
        chk_slot(0, 10, 8'h00, 8'h00);
        chk_slot(1, 12, 8'h00, 8'h00);
        $display("test serial slots done");
        chk_word(32'(ccap[2]), 32'h0000_0003);
        chk_word(32'(ccap[11]), 32'h0000_000c);
        chk_word(32'(ccap[10]), 32'h0000_0000);
        $display("test control pin done");
        // frame 5 has just begun: channel 0, even bank, running
        rd(12'h204, d, r);
        chk_word(d, 32'h0001_0000);
        $display("test status done");
        end_sim();
    end
endmodule // tsw_conn_word_decode_bench
`default_nettype wire
